// *** pkg/fmr_pkg.sv ***
// Purpose: Shared constants and types for the parallel boot-sector flash host controller.
// Assumes: The controller clock runs at 20 MHz; all flash times below are in nanoseconds.
// Notes:   Cycle counts are derived from the times; least times round up, longest round down.
package fmr_pkg;

    // ------------------------------------------------------------------
    // Clock and flash timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Chip-select access time from standby; also covers address access.
    localparam int unsigned CE_ACCESS_NS = 70;
    localparam int unsigned WE_PULSE_NS = 35;
    localparam int unsigned RESET_PULSE_MIN_NS = 500;
    localparam int unsigned RESET_HIGH_TO_READ_NS = 50;
    // Longest internal reset recovery while an embedded algorithm runs.
    localparam int unsigned RESET_READY_NS = 20000;

    function automatic int unsigned ns_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_up

    function automatic int unsigned ns_dn(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_dn

    localparam int unsigned ACC_CYC = ns_up(CE_ACCESS_NS);
    localparam int unsigned WP_CYC = ns_up(WE_PULSE_NS);
    localparam int unsigned RP_CYC = ns_up(RESET_PULSE_MIN_NS);
    localparam int unsigned RH_CYC = ns_up(RESET_HIGH_TO_READ_NS);
    localparam int unsigned READY_CYC = ns_dn(RESET_READY_NS);
    localparam int unsigned CNT_W = 9;

    // ------------------------------------------------------------------
    // Bus layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned SECTOR_W = 5;
    // Secured region is the top or bottom 256 bytes, i.e. pin address bits 18 to 7.
    localparam int unsigned SECURED_LSB = 7;
    localparam logic [15:0] DQ_OE_N_IDLE = 16'hFFFF;
    localparam logic [15:0] DQ_OE_N_BYTE_RD = 16'h7FFF;
    localparam logic [15:0] DQ_OE_N_BYTE_WR = 16'h7F00;
    localparam logic [15:0] DQ_OE_N_WORD_WR = 16'h0000;

    typedef enum logic [1:0] {
        FMR_OP_READ = 2'b00,
        FMR_OP_WRITE = 2'b01,
        FMR_OP_RESET = 2'b10
    } fmr_op_e;

    // Address is a byte address in byte mode and a word address in word mode.
    typedef struct packed {
        fmr_op_e op;
        logic [19:0] addr;
        logic [15:0] wdata;
    } fmr_req_s;

    typedef struct packed {
        logic [15:0] data;
        logic was_write;
        logic busy;
        logic timeout;
        logic secured;
        logic [SECTOR_W-1:0] sector;
    } fmr_rsp_s;

endpackage : fmr_pkg

// *** rtl/fmr_sector_dec.sv ***
// Purpose: Sector index and secured-region decode from the flash pin address.
// Assumes: Pin address bits 18 to 12 pick the sector in both byte and word mode.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none

module fmr_sector_dec #(
    parameter bit TOP_BOOT = 1'b1
) (
    // Pin address
    input wire logic [fmr_pkg::ADDR_W-1:0] addr_i,
    // Decode results
    output logic [fmr_pkg::SECTOR_W-1:0] sector_o,
    output logic secured_o
);

    wire [3:0] hi = addr_i[18:15];
    wire [fmr_pkg::ADDR_W-1-fmr_pkg::SECURED_LSB:0] sec_bits = addr_i[18:fmr_pkg::SECURED_LSB];

    // Top boot: fifteen big sectors, then 32 KB, two 8 KB and the final 16 KB.
    wire [4:0] top_idx = (hi != 4'hF) ? {1'b0, hi} :
                         !addr_i[14] ? 5'h0F :
                         !addr_i[13] ? (5'h10 + {4'h0, addr_i[12]}) : 5'h12;
    // Bottom boot: 16 KB, two 8 KB, one 32 KB, then fifteen big sectors.
    wire [4:0] bot_idx = (hi != 4'h0) ? ({1'b0, hi} + 5'h03) :
                         addr_i[14] ? 5'h03 :
                         !addr_i[13] ? 5'h00 : (5'h01 + {4'h0, addr_i[12]});

    // Byte and word ranges map to the same pin bits, so one compare serves both units.
    assign sector_o = TOP_BOOT ? top_idx : bot_idx;
    assign secured_o = TOP_BOOT ? (&sec_bits) : ~(|sec_bits);

endmodule : fmr_sector_dec

`default_nettype wire

// *** rtl/fmr_host.sv ***
// Purpose: Host-side controller that runs read, write and hardware-reset cycles on a
//          parallel boot-sector flash through its pins.
// Assumes: Flash pins are synchronous to ref_clk_i; one request at a time.
// Notes:   Holds chip select and reset high when idle so the flash sits in standby.
//
// Notes on behaviour
// - Reads during program or erase return status; flagged by sampled busy.
// - After standby wait the full chip-select access time before sampling.
// - Program or erase cut short by a hardware reset is flagged on interrupted_o; the user reissues it.
// - After reset release wait reset-high-to-read before any read.
`timescale 1ns/10ps
`default_nettype none

module fmr_host #(
    parameter bit TOP_BOOT = 1'b1,
    parameter int unsigned READY_CYC = fmr_pkg::READY_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // User request and response
    input wire logic req_valid_i,
    input wire fmr_pkg::fmr_req_s req_i,
    input wire logic byte_mode_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output fmr_pkg::fmr_rsp_s rsp_o,
    output logic interrupted_o,
    // Flash control pins
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic flash_reset_n_o,
    output logic flash_byte_n_o,
    output logic [fmr_pkg::ADDR_W-1:0] flash_addr_o,
    input wire logic ready_busy_n_i,
    // Flash data pins
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_n_o,
    input wire logic [15:0] dq_i
);

    localparam int unsigned CW = fmr_pkg::CNT_W;

    generate
        if (READY_CYC < 1 || READY_CYC >= (1 << CW))
        begin : g_bad_ready
            $error("READY_CYC does not fit the cycle counter");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FMR_ST_IDLE = 3'b000,
        FMR_ST_READ = 3'b001,
        FMR_ST_WR_LOW = 3'b010,
        FMR_ST_WR_HOLD = 3'b011,
        FMR_ST_RST_LOW = 3'b100,
        FMR_ST_RST_REC = 3'b101,
        FMR_ST_RST_RH = 3'b110
    } fmr_state_e;

    fmr_state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic ce_n_r, ce_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic we_n_r, we_n_nxt;
    logic frst_n_r, frst_n_nxt;
    logic byte_n_r, byte_n_nxt;
    logic [fmr_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [15:0] dq_r, dq_nxt;
    logic [15:0] dq_oe_n_r, dq_oe_n_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    fmr_pkg::fmr_rsp_s rsp_r, rsp_nxt;
    logic intr_r, intr_nxt;
    logic [fmr_pkg::SECTOR_W-1:0] dec_sector;
    logic dec_secured;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    wire accept = req_valid_i && ready_r;
    wire [fmr_pkg::ADDR_W-1:0] pin_addr = byte_mode_i ? req_i.addr[19:1] : req_i.addr[18:0];
    // In byte mode line 15 carries the extra low address bit and lines 8 to 14 stay released.
    wire [15:0] rd_oe_n = byte_mode_i ? fmr_pkg::DQ_OE_N_BYTE_RD : fmr_pkg::DQ_OE_N_IDLE;
    wire [15:0] wr_oe_n = byte_mode_i ? fmr_pkg::DQ_OE_N_BYTE_WR : fmr_pkg::DQ_OE_N_WORD_WR;
    wire [15:0] wr_dq = byte_mode_i ? {req_i.addr[0], 7'h00, req_i.wdata[7:0]} : req_i.wdata;
    wire [15:0] rd_dq = {req_i.addr[0] & byte_mode_i, 15'h0000};
    wire [15:0] rd_data = byte_n_r ? dq_i : {8'h00, dq_i[7:0]};
    wire cnt_done = (cnt_r == '0);

    fmr_sector_dec #(
        .TOP_BOOT(TOP_BOOT)
    ) u_dec (
        .addr_i(pin_addr),
        .sector_o(dec_sector),
        .secured_o(dec_secured)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        frst_n_nxt = frst_n_r;
        byte_n_nxt = byte_n_r;
        addr_nxt = addr_r;
        dq_nxt = dq_r;
        dq_oe_n_nxt = dq_oe_n_r;
        ready_nxt = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        intr_nxt = intr_r;
        case (state_r)
            FMR_ST_IDLE:
            begin
                // Address is left as it was so the sleeping flash keeps its last data.
                if (accept)
                begin
                    ready_nxt = 1'b0;
                    byte_n_nxt = ~byte_mode_i;
                    rsp_nxt.sector = dec_sector;
                    rsp_nxt.secured = dec_secured;
                    rsp_nxt.was_write = (req_i.op == fmr_pkg::FMR_OP_WRITE);
                    rsp_nxt.timeout = 1'b0;
                    rsp_nxt.busy = 1'b0;
                    rsp_nxt.data = '0;
                    case (req_i.op)
                        fmr_pkg::FMR_OP_WRITE:
                        begin
                            // Output gate stays high so the flash never fights our drive.
                            addr_nxt = pin_addr;
                            ce_n_nxt = 1'b0;
                            we_n_nxt = 1'b0;
                            dq_nxt = wr_dq;
                            dq_oe_n_nxt = wr_oe_n;
                            cnt_nxt = CW'(fmr_pkg::WP_CYC - 1);
                            intr_nxt = 1'b0;
                            state_nxt = FMR_ST_WR_LOW;
                        end
                        fmr_pkg::FMR_OP_RESET:
                        begin
                            frst_n_nxt = 1'b0;
                            dq_oe_n_nxt = fmr_pkg::DQ_OE_N_IDLE;
                            // A program or erase cut short must be redone by software.
                            intr_nxt = intr_r | ~ready_busy_n_i;
                            cnt_nxt = CW'(fmr_pkg::RP_CYC - 1);
                            state_nxt = FMR_ST_RST_LOW;
                        end
                        default:
                        begin
                            // Plain reads need no command; status appears on the same cycle.
                            addr_nxt = pin_addr;
                            ce_n_nxt = 1'b0;
                            oe_n_nxt = 1'b0;
                            dq_nxt = rd_dq;
                            dq_oe_n_nxt = rd_oe_n;
                            cnt_nxt = CW'(fmr_pkg::ACC_CYC - 1);
                            state_nxt = FMR_ST_READ;
                        end
                    endcase
                end
            end
            FMR_ST_READ:
            begin
                if (cnt_done)
                begin
                    rsp_nxt.data = rd_data;
                    rsp_nxt.busy = ~ready_busy_n_i;
                    rsp_valid_nxt = 1'b1;
                    ce_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    dq_oe_n_nxt = fmr_pkg::DQ_OE_N_IDLE;
                    ready_nxt = 1'b1;
                    state_nxt = FMR_ST_IDLE;
                end
            end
            FMR_ST_WR_LOW:
            begin
                if (cnt_done)
                begin
                    we_n_nxt = 1'b1;
                    state_nxt = FMR_ST_WR_HOLD;
                end
            end
            FMR_ST_WR_HOLD:
            begin
                // Deselecting now is safe: an embedded algorithm carries on inside.
                ce_n_nxt = 1'b1;
                dq_oe_n_nxt = fmr_pkg::DQ_OE_N_IDLE;
                rsp_valid_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = FMR_ST_IDLE;
            end
            FMR_ST_RST_LOW:
            begin
                if (cnt_done)
                begin
                    frst_n_nxt = 1'b1;
                    cnt_nxt = CW'(READY_CYC - 1);
                    state_nxt = FMR_ST_RST_REC;
                end
            end
            FMR_ST_RST_REC:
            begin
                // Busy low means the aborted algorithm is still unwinding.
                if (ready_busy_n_i || cnt_done)
                begin
                    rsp_nxt.timeout = ~ready_busy_n_i;
                    cnt_nxt = CW'(fmr_pkg::RH_CYC - 1);
                    state_nxt = FMR_ST_RST_RH;
                end
            end
            FMR_ST_RST_RH:
            begin
                // The flash comes back in read-array state, so plain reads follow with no command.
                if (cnt_done)
                begin
                    rsp_valid_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = FMR_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = FMR_ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= FMR_ST_IDLE;
            cnt_r <= '0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            frst_n_r <= 1'b1;
            byte_n_r <= 1'b1;
            addr_r <= '0;
            dq_r <= '0;
            dq_oe_n_r <= fmr_pkg::DQ_OE_N_IDLE;
            ready_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            intr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            frst_n_r <= frst_n_nxt;
            byte_n_r <= byte_n_nxt;
            addr_r <= addr_nxt;
            dq_r <= dq_nxt;
            dq_oe_n_r <= dq_oe_n_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            intr_r <= intr_nxt;
        end
    end

    assign req_ready_o = ready_r;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_o = rsp_r;
    assign interrupted_o = intr_r;
    assign flash_ce_n_o = ce_n_r;
    assign flash_oe_n_o = oe_n_r;
    assign flash_we_n_o = we_n_r;
    assign flash_reset_n_o = frst_n_r;
    assign flash_byte_n_o = byte_n_r;
    assign flash_addr_o = addr_r;
    assign dq_o = dq_r;
    assign dq_oe_n_o = dq_oe_n_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam int REC_MAX = READY_CYC + fmr_pkg::RH_CYC + 2;
    logic [7:0] ce_low_cnt_r;
    logic [7:0] rst_low_cnt_r;

    always_ff @(posedge ref_clk_i)
    begin
        ce_low_cnt_r <= (reset_i || ce_n_r) ? 8'h00 : ce_low_cnt_r + 8'h01;
        rst_low_cnt_r <= (reset_i || frst_n_r) ? 8'h00 : rst_low_cnt_r + 8'h01;
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    // Reset answers also carry was_write low; of those, only a read had chip select low in the cycle before its answer.
    chk_read_access: assert property (rsp_valid_o && !rsp_o.was_write && !$past(flash_ce_n_o)
        |-> ce_low_cnt_r == fmr_pkg::ACC_CYC)
        else $error("read sampled before chip-select access time");
    chk_read_status: assert property (rsp_valid_o && !rsp_o.was_write && !$past(flash_ce_n_o)
        |-> rsp_o.busy == !$past(ready_busy_n_i))
        else $error("read status does not match busy line");
    chk_write_gate: assert property (!flash_we_n_o || !(&dq_oe_n_o[7:0]) |-> flash_oe_n_o)
        else $error("data driven while output gate low");
    chk_idle_standby: assert property (ready_r |-> flash_ce_n_o && flash_reset_n_o && (&dq_oe_n_o))
        else $error("idle without standby levels");
    chk_reset_width: assert property ($rose(flash_reset_n_o) |-> rst_low_cnt_r == fmr_pkg::RP_CYC)
        else $error("reset pulse width wrong");
    chk_reset_to_read: assert property ($rose(flash_reset_n_o) |-> flash_ce_n_o [*2])
        else $error("access too soon after reset release");
    chk_reset_recovery: assert property ($rose(flash_reset_n_o) |-> ##[1:REC_MAX] rsp_valid_o)
        else $error("reset recovery did not end in time");
    chk_reissue_flag: assert property ($fell(flash_reset_n_o) && !$past(ready_busy_n_i) |-> interrupted_o)
        else $error("interrupted operation not flagged");
    chk_byte_lane: assert property (!flash_ce_n_o && !flash_byte_n_o |-> !dq_oe_n_o[15] && (&dq_oe_n_o[14:8]))
        else $error("byte mode lane use wrong");

endmodule : fmr_host

`default_nettype wire

// *** tb/fmr_flash_model.sv ***
// Purpose: Behavioural model of the boot-sector parallel flash that sits on the host controller's pins.
// Assumes: Pins change just after ref_clk_i edges; the array holds a fixed address pattern.
// Notes:   A write starts a busy period; reset recovery length comes from rec_cyc_i.
`timescale 1ns/10ps
`default_nettype none

module fmr_flash_model #(
    parameter int unsigned CLK_NS = 50,
    parameter int unsigned ACC_NS = 70,
    parameter int unsigned PROG_CYC = 30
) (
    // Clock
    input wire logic clk_i,
    // Control pins
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    input wire logic byte_n_i,
    input wire logic [18:0] addr_i,
    input wire logic [15:0] dq_bus_i,
    input wire logic [7:0] rec_cyc_i,
    // Flash outputs
    output logic [15:0] dq_o,
    output logic [15:0] dq_en_o,
    output logic ready_busy_n_o
);
    logic [7:0] busy_r = 8'h00;
    logic [7:0] rec_r = 8'h00;
    logic [3:0] acc_r;
    logic [18:0] addr_r;
    logic we_n_r;
    logic wd7_r;
    logic tog_r = 1'b0;
    logic [19:0] baddr;
    logic [18:0] wa;
    logic [15:0] word;
    logic [15:0] data;
    logic rd_en;

    // A flash powers up idle and ready, so busy, recovery and toggle state start from their declared values.
    always @(posedge clk_i)
    begin
        we_n_r <= we_n_i;
        addr_r <= addr_i;
        tog_r <= ~tog_r;
        // Data becomes valid only once select and address have stood for the access time.
        acc_r <= ce_n_i ? 4'h0 : (addr_i != addr_r) ? 4'h1 : (acc_r == 4'hF) ? acc_r : acc_r + 4'h1;
        if (!reset_n_i)
        begin
            busy_r <= 8'h00;
            rec_r <= (busy_r != 8'h00) ? rec_cyc_i : (rec_r != 8'h00) ? rec_r - 8'h01 : 8'h00;
        end
        else
        begin
            if (rec_r != 8'h00) rec_r <= rec_r - 8'h01;
            if (!ce_n_i && !we_n_i) wd7_r <= dq_bus_i[7];
            if (busy_r != 8'h00) busy_r <= busy_r - 8'h01;
            else if (!ce_n_i && !we_n_r && we_n_i) busy_r <= 8'(PROG_CYC);
        end
    end

    assign ready_busy_n_o = (busy_r == 8'h00) && (rec_r == 8'h00);
    assign rd_en = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
    assign baddr = {addr_i, dq_bus_i[15]};
    assign wa = byte_n_i ? addr_i : baddr[19:1];
    assign word = wa[15:0] ^ {wa[18:16], wa[18:16], 10'h2B7};
    assign data = (busy_r != 8'h00) ? {8'h00, ~wd7_r, tog_r, 6'h00} :
                  byte_n_i ? word : {8'h00, baddr[0] ? word[15:8] : word[7:0]};
    assign dq_o = ((32'(acc_r) + 1) * CLK_NS >= ACC_NS) ? data : ~data;
    assign dq_en_o = !rd_en ? 16'h0000 : byte_n_i ? 16'hFFFF : 16'h00FF;
endmodule : fmr_flash_model

`default_nettype wire

// *** tb/flash_mode_reset_sector_map_bench.sv ***
// Purpose: Self-checking bench for the flash host controller, top-boot and bottom-boot builds.
// Assumes: The bottom-boot copy only sees a released bus and an idle ready line.
// Notes:   Undriven data lines carry a pattern that changes every cycle.
`timescale 1ns/10ps
`default_nettype none

module flash_mode_reset_sector_map_bench;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic byte_mode_i = 1'b0;
    fmr_pkg::fmr_req_s req_i = '0;
    logic req_ready_o, rsp_valid_o, interrupted_o, bot_valid;
    fmr_pkg::fmr_rsp_s rsp_o, bot_rsp;
    logic ce_n, oe_n, we_n, rst_n, byte_n, ready_busy_n;
    logic [18:0] addr;
    logic [15:0] dq_h, dq_oe_n, dq_bus, fl_d, fl_en, flt;
    logic [7:0] rec_cyc = 8'h00;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed;
    localparam logic [19:0] CORN [0:16] = '{20'h00000, 20'h000FF, 20'h00100, 20'h03FFF, 20'h04000,
        20'h05FFF, 20'h06000, 20'h08000, 20'h10000, 20'hEFFFF, 20'hF7FFF, 20'hF8000, 20'hFA000,
        20'hFC000, 20'hFFEFF, 20'hFFF00, 20'hFFFFF};

    always #25 ref_clk_i = ~ref_clk_i;
    assign flt = cyc[0] ? 16'hA5A5 : 16'h5A5A;
    assign dq_bus = (~dq_oe_n & dq_h) | (dq_oe_n & fl_en & fl_d) | (dq_oe_n & ~fl_en & flt);

    fmr_host #(.TOP_BOOT(1'b1), .READY_CYC(8)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .byte_mode_i(byte_mode_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .interrupted_o(interrupted_o), .flash_ce_n_o(ce_n),
        .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_reset_n_o(rst_n), .flash_byte_n_o(byte_n),
        .flash_addr_o(addr), .ready_busy_n_i(ready_busy_n), .dq_o(dq_h), .dq_oe_n_o(dq_oe_n), .dq_i(dq_bus));
    fmr_host #(.TOP_BOOT(1'b0), .READY_CYC(8)) dut_bot_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .byte_mode_i(byte_mode_i), .req_ready_o(),
        .rsp_valid_o(bot_valid), .rsp_o(bot_rsp), .interrupted_o(), .flash_ce_n_o(), .flash_oe_n_o(),
        .flash_we_n_o(), .flash_reset_n_o(), .flash_byte_n_o(), .flash_addr_o(), .ready_busy_n_i(1'b1),
        .dq_o(), .dq_oe_n_o(), .dq_i(flt));
    fmr_flash_model flash_u (.clk_i(ref_clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .reset_n_i(rst_n), .byte_n_i(byte_n), .addr_i(addr), .dq_bus_i(dq_bus), .rec_cyc_i(rec_cyc),
        .dq_o(fl_d), .dq_en_o(fl_en), .ready_busy_n_o(ready_busy_n));

    // ------------------------------------------------------------------
    // Checking and expectations
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    function automatic logic [4:0] sec_of(input logic [18:0] p, input logic top);
        if (top)
        begin
            if (p[18:15] != 4'hF) return {1'b0, p[18:15]};
            if (!p[14]) return 5'h0F;
            if (p[13]) return 5'h12;
            return 5'h10 + {4'h0, p[12]};
        end
        if (p[18:15] != 4'h0) return {1'b0, p[18:15]} + 5'h03;
        if (p[14]) return 5'h03;
        if (!p[13]) return 5'h00;
        return 5'h01 + {4'h0, p[12]};
    endfunction : sec_of

    function automatic logic [15:0] exp_data(input logic [19:0] a, input logic bm);
        logic [18:0] wa;
        logic [15:0] w;
        wa = bm ? a[19:1] : a[18:0];
        w = wa[15:0] ^ {wa[18:16], wa[18:16], 10'h2B7};
        return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    endfunction : exp_data

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------------
    task automatic issue(input fmr_pkg::fmr_op_e op, input logic [19:0] a, input logic [15:0] wd,
                         input logic bm, output int lat);
        int n;
        logic [18:0] p;
        n = 0;
        p = bm ? a[19:1] : a[18:0];
        while (req_ready_o !== 1'b1 && n < 500)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        req_valid_i = 1'b1;
        req_i = '{op: op, addr: a, wdata: wd};
        byte_mode_i = bm;
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        lat = 1;
        while (rsp_valid_o !== 1'b1 && lat < 600)
        begin
            @(negedge ref_clk_i);
            lat++;
        end
        // The bottom-boot copy answers every read in step with the top-boot one; checked here to avoid a race.
        if (op == fmr_pkg::FMR_OP_READ)
        begin
            cmp("bot_valid", 32'(bot_valid), 32'h1);
            cmp("bot_sector", 32'(bot_rsp.sector), 32'(sec_of(p, 1'b0)));
            cmp("bot_secured", 32'(bot_rsp.secured), 32'(~|p[18:7]));
        end
    endtask : issue

    task automatic rd(input logic [19:0] a, input logic bm);
        int lat;
        logic [18:0] p;
        p = bm ? a[19:1] : a[18:0];
        issue(fmr_pkg::FMR_OP_READ, a, 16'h0000, bm, lat);
        cmp("rd_latency", 32'(lat), 32'h3);
        cmp("rd_data", 32'(rsp_o.data), 32'(exp_data(a, bm)));
        cmp("rd_busy", 32'(rsp_o.busy), 32'h0);
        cmp("sector", 32'(rsp_o.sector), 32'(sec_of(p, 1'b1)));
        cmp("secured", 32'(rsp_o.secured), 32'(&p[18:7]));
        cmp("standby", 32'({ce_n, rst_n, dq_oe_n}), 32'h3FFFF);
        cmp("addr_hold", 32'(addr), 32'(p));
    endtask : rd

    task automatic wr_busy(input logic [19:0] a, output logic [15:0] wd);
        int lat;
        wd = 16'($random(seed));
        issue(fmr_pkg::FMR_OP_WRITE, a, wd, 1'b0, lat);
        cmp("wr_done", 32'({rsp_o.was_write, interrupted_o}), 32'h2);
    endtask : wr_busy

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_busy_n !== 1'b1 && n < 200)
        begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask : wait_ready

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int lat;
        logic [31:0] r;
        logic [15:0] wd;
        seed = 32'h1530cdf1;
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        @(negedge ref_clk_i);
        foreach (CORN[i])
        begin
            rd(CORN[i], 1'b1);
            rd({1'b0, CORN[i][19:1]}, 1'b0);
        end
        $display("test sector corners done");
        repeat (40)
        begin
            r = $random(seed);
            rd(r[0] ? r[19:0] : {1'b0, r[18:0]}, r[0]);
        end
        $display("test random reads done");
        wr_busy(20'h12345, wd);
        issue(fmr_pkg::FMR_OP_READ, 20'h12345, 16'h0000, 1'b0, lat);
        cmp("status", 32'({rsp_o.busy, rsp_o.data[7]}), 32'({1'b1, ~wd[7]}));
        wait_ready();
        rd(20'h12345, 1'b0);
        $display("test status read done");
        issue(fmr_pkg::FMR_OP_RESET, 20'h00000, 16'h0000, 1'b0, lat);
        cmp("idle_reset", 32'({lat[7:0], rsp_o.timeout, interrupted_o}), 32'h34);
        rd(20'h0ABCD, 1'b1);
        rec_cyc = 8'h0D;
        wr_busy(20'h00777, wd);
        issue(fmr_pkg::FMR_OP_RESET, 20'h00000, 16'h0000, 1'b0, lat);
        cmp("busy_reset", 32'({rsp_o.timeout, interrupted_o, lat > 13 && lat <= 20}), 32'h3);
        wait_ready();
        wr_busy(20'h00777, wd);
        wait_ready();
        rec_cyc = 8'h28;
        wr_busy(20'h00777, wd);
        issue(fmr_pkg::FMR_OP_RESET, 20'h00000, 16'h0000, 1'b0, lat);
        cmp("reset_timeout", 32'(rsp_o.timeout), 32'h1);
        wait_ready();
        rd(20'h7FFFF, 1'b0);
        $display("test hardware reset done");
        end_of_test();
    end
endmodule : flash_mode_reset_sector_map_bench

`default_nettype wire
